// ===== core/anps_partner_status.sv
// How it works
// - partner ability register is read-only; writes never change it
// - ability register loads received base word; zero at reset
// - bit 15 shows partner next-page request
// - bit 14 shows partner acknowledge bit
// - bit 13 shows partner remote fault
// - bits 12:5 hold partner technology abilities as received, except reserved bit 11, which is cleared
// - reserved ability code reads zero; partner must not send it
// - bits 4:0 hold partner selector, expected to match local one
// - expansion bit 4 latches parallel-detect fault until read
// - expansion bit 1 latches page received until read
// - expansion bit 3 shows partner next-page capability
// - expansion bit 2 shows local next-page capability, one at reset
// - expansion bit 0 shows partner auto-negotiation capability
module anps_partner_status
    import anps_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // from the negotiation receive logic, same clock
    input wire logic [15:0] rx_base_word,
    input wire logic rx_base_valid,
    input wire logic parallel_detect_fault,
    input wire logic page_received,
    input wire logic partner_next_page_capable,
    input wire logic partner_autoneg_capable,
    // status to the negotiation logic
    output logic selector_mismatch,
    output logic local_next_page_capable,
    // interrupt
    output logic irq
);
    anps_evt_if evt ();

    anps_latch u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .evt(evt)
    );

    function automatic logic [ADDR_W-1:0] reg_index(input logic [31:0] a);
        return a[ADDR_LSB +: ADDR_W];
    endfunction

    // sanitise the received word: the reserved ability code never shows
    function automatic logic [15:0] clean_word(input logic [15:0] w);
        logic [15:0] r;
        r = w;
        r[TECH_LO +: 8] = w[TECH_HI:TECH_LO] & ~TECH_RESERVED_MASK;
        return r;
    endfunction

    logic [15:0] ability_q, ability_d;
    logic [1:0] irq_st_q, irq_st_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic local_np_q, local_np_d;
    logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d;
    logic [ADDR_W-1:0] awidx_q, awidx_d;
    logic [31:0] wdata_q, wdata_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [15:0] expansion;
    logic rd_take, wr_go;
    logic [ADDR_W-1:0] rdidx;

    // live expansion view built from latches and partner status
    always_comb begin
        expansion = '0;
        expansion[PDF_BIT] = evt.pdf_flag;
        expansion[PARTNER_NP_BIT] = partner_next_page_capable;
        expansion[LOCAL_NP_BIT] = local_np_q;
        expansion[PAGE_RX_BIT] = evt.page_flag;
        expansion[PARTNER_AN_BIT] = partner_autoneg_capable;
    end

    assign rd_take = s_axi_arvalid & ~rvalid_q;
    assign rdidx = reg_index(s_axi_araddr);
    assign wr_go = aw_q & w_q & ~bvalid_q;

    // event carrier: clear only on a taken expansion read
    assign evt.pdf_set = parallel_detect_fault;
    assign evt.page_set = page_received;
    assign evt.clear_rd = rd_take & (rdidx == IDX_EXPANSION);

    // ability word and control state
    always_comb begin
        ability_d = ability_q;
        irq_mask_d = irq_mask_q;
        local_np_d = local_np_q;
        irq_st_d = irq_st_q;
        if (rx_base_valid) begin
            ability_d = clean_word(rx_base_word);
        end
        // writes touch only mask and local control; ability is never a target
        // ability is read-only
        if (wr_go) begin
            if (awidx_q == IDX_IRQ_MASK) begin
                irq_mask_d = wdata_q[IRQ_W-1:0];
            end
            if (awidx_q == IDX_LOCAL_CTRL) begin
                local_np_d = wdata_q[0];
            end
        end
        // sticky interrupt status, read clears, new event wins
        if (rd_take && rdidx == IDX_IRQ_STATUS) begin
            irq_st_d = '0;
        end
        if (parallel_detect_fault) begin
            irq_st_d[IRQ_PDF] = 1'b1;
        end
        if (page_received) begin
            irq_st_d[IRQ_PAGE] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ability_q <= ABILITY_RESET;
            irq_mask_q <= IRQ_MASK_RESET;
            local_np_q <= LOCAL_NP_RESET;
            irq_st_q <= '0;
        end else begin
            ability_q <= ability_d;
            irq_mask_q <= irq_mask_d;
            local_np_q <= local_np_d;
            irq_st_q <= irq_st_d;
        end
    end

    // write channel: address and data taken in either order
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awidx_d = awidx_q;
        wdata_d = wdata_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awidx_d = reg_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_q) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            // read-only and status registers accept writes silently
            case (awidx_q)
                IDX_PARTNER_ABILITY, IDX_EXPANSION, IDX_IRQ_STATUS,
                IDX_IRQ_MASK, IDX_LOCAL_CTRL: bresp_d = RESP_OKAY;
                default: bresp_d = RESP_SLVERR;
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awidx_q <= '0;
            wdata_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            awidx_q <= awidx_d;
            wdata_q <= wdata_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // read channel: data snapshot taken with the address
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_take) begin
            rvalid_d = 1'b1;
            rdata_d = '0;
            rresp_d = RESP_OKAY;
            case (rdidx)
                IDX_PARTNER_ABILITY: rdata_d[15:0] = ability_q;
                IDX_EXPANSION: rdata_d[15:0] = expansion;
                IDX_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_st_q;
                IDX_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
                IDX_LOCAL_CTRL: rdata_d[0] = local_np_q;
                default: rresp_d = RESP_SLVERR;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = ~aw_q;
    assign s_axi_wready = ~w_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign selector_mismatch =
        ability_q[SEL_HI:SEL_LO] != ETHERNET_SELECTOR_VALUE;
    assign local_next_page_capable = local_np_q;
    assign irq = |(irq_st_q & irq_mask_q);

    ability_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_base_valid |=> ability_q == $past(ability_q))
        else $error("ability changed without receive");
    ability_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_base_valid |=> ability_q[15:13] == $past(rx_base_word[15:13])
        && ability_q[SEL_HI:SEL_LO] == $past(rx_base_word[SEL_HI:SEL_LO]))
        else $error("ability not loaded");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ability_q[TECH_LO+6] == 1'b0)
        else $error("reserved ability bit set");
    exp_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rd_take && rdidx == IDX_EXPANSION) |=>
        rdata_q[PARTNER_AN_BIT] == $past(partner_autoneg_capable)
        && rdata_q[15:5] == '0)
        else $error("expansion read wrong");
    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (irq_st_q[IRQ_PAGE] && irq_mask_q[IRQ_PAGE]) |-> irq)
        else $error("irq not raised");
endmodule

// ===== core/anps_pkg.sv
package anps_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_PARTNER_ABILITY = 8'h05;
    localparam logic [7:0] IDX_EXPANSION = 8'h06;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
    localparam logic [7:0] IDX_LOCAL_CTRL = 8'h12;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 8;

    // reset values
    localparam logic [15:0] ABILITY_RESET = 16'h0000;
    localparam logic [15:0] EXPANSION_RESET = 16'h0004;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic LOCAL_NP_RESET = 1'b1;

    // partner ability field positions
    localparam int NEXT_PAGE_BIT = 15;
    localparam int ACK_BIT = 14;
    localparam int REMOTE_FAULT_BIT = 13;
    localparam int TECH_HI = 12;
    localparam int TECH_LO = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 0;
    localparam logic [7:0] TECH_RESERVED_MASK = 8'h40;
    localparam logic [4:0] ETHERNET_SELECTOR_VALUE = 5'h01;

    // expansion field positions
    localparam int PDF_BIT = 4;
    localparam int PARTNER_NP_BIT = 3;
    localparam int LOCAL_NP_BIT = 2;
    localparam int PAGE_RX_BIT = 1;
    localparam int PARTNER_AN_BIT = 0;

    // interrupt status / mask layout
    localparam int IRQ_PDF = 0;
    localparam int IRQ_PAGE = 1;
    localparam int IRQ_W = 2;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/anps_evt_if.sv
// latched event flags shared between the register core and the latch module
interface anps_evt_if;
    logic pdf_set;
    logic page_set;
    logic clear_rd;
    logic pdf_flag;
    logic page_flag;
    modport core (output pdf_set, output page_set, output clear_rd,
                  input pdf_flag, input page_flag);
    modport latch (input pdf_set, input page_set, input clear_rd,
                   output pdf_flag, output page_flag);
endinterface

// ===== core/anps_latch.sv
module anps_latch
    import anps_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // event carrier
    anps_evt_if.latch evt
);
    logic pdf_q, pdf_d, page_q, page_d;

    // latch-high flags; an event in the read cycle wins over the clear
    always_comb begin
        pdf_d = evt.pdf_set | (pdf_q & ~evt.clear_rd);
        page_d = evt.page_set | (page_q & ~evt.clear_rd);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pdf_q <= EXPANSION_RESET[PDF_BIT];
            page_q <= EXPANSION_RESET[PAGE_RX_BIT];
        end else begin
            pdf_q <= pdf_d;
            page_q <= page_d;
        end
    end

    assign evt.pdf_flag = pdf_q;
    assign evt.page_flag = page_q;

    set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        evt.pdf_set |=> pdf_q) else $error("fault event lost");
    read_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (evt.clear_rd && !evt.page_set) |=> !page_q)
        else $error("page flag not cleared on read");
    flag_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (pdf_q && !evt.clear_rd) |=> pdf_q)
        else $error("fault flag dropped without read");
endmodule

// ===== verification/anps_link_partner.sv
// remote link partner: base pages, event pulses, capability levels
module anps_link_partner (
    // clock
    input wire logic aclk,
    // received page and events
    output logic [15:0] rx_base_word,
    output logic rx_base_valid,
    output logic parallel_detect_fault,
    output logic page_received,
    // capability levels
    output logic partner_next_page_capable,
    output logic partner_autoneg_capable
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet outputs at time zero
    initial begin
        rx_base_word = 16'h0000;
        rx_base_valid = 1'b0;
        parallel_detect_fault = 1'b0;
        page_received = 1'b0;
        partner_next_page_capable = 1'b0;
        partner_autoneg_capable = 1'b0;
    end

    // one page for one cycle; the stale word is inverted, not held
    task automatic send(input logic [15:0] w, input logic rogue);
        logic [15:0] v;
        v = rogue ? w : (w & 16'hf7ff);
        rx_base_word <= v;
        rx_base_valid <= 1'b1;
        page_received <= 1'b1;
        @(posedge aclk);
        rx_base_word <= ~v;
        rx_base_valid <= 1'b0;
        page_received <= 1'b0;
    endtask

    // one-cycle parallel-detect fault
    task automatic fault();
        parallel_detect_fault <= 1'b1;
        @(posedge aclk);
        parallel_detect_fault <= 1'b0;
    endtask

    // levels stay until changed
    task automatic caps(input logic np, input logic an);
        partner_next_page_capable <= np;
        partner_autoneg_capable <= an;
    endtask
endmodule

// ===== verification/tb_top.sv
module tb_top import anps_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0] word;
        logic [15:0] exp;
    } anps_row_s;

    // bus, link and status signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, selector_mismatch, local_next_page_capable, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] rx_base_word;
    logic rx_base_valid, parallel_detect_fault, page_received;
    logic partner_next_page_capable, partner_autoneg_capable;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    // one tech code per row up to the 0801 row; the 0801 and 1fe2 rows command a rogue reserved bit
    // top bits row
    anps_row_s rows [9] = '{
        '{16'h0021, 16'h0021}, '{16'h0041, 16'h0041}, '{16'h0081, 16'h0081},
        '{16'h0101, 16'h0101}, '{16'h0201, 16'h0201}, '{16'h0401, 16'h0401},
        '{16'h0801, 16'h0001}, '{16'he001, 16'he001}, '{16'h1fe2, 16'h17e2}
    };

    anps_partner_status u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rx_base_word, .rx_base_valid,
        .parallel_detect_fault, .page_received, .partner_next_page_capable,
        .partner_autoneg_capable, .selector_mismatch,
        .local_next_page_capable, .irq
    );

    anps_link_partner u_lp (
        .aclk, .rx_base_word, .rx_base_valid, .parallel_detect_fault,
        .page_received, .partner_next_page_capable, .partner_autoneg_capable
    );

    // 25 mhz clock
    always #20 aclk = ~aclk;

    // cut a hang short far beyond the expected run length
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read; one idle edge at the end so the next task never collides
    task automatic rd_word(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // write; address and data released each when taken
    task automatic wr_word(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok || s_axi_awready === 1'b1;
            w_ok = w_ok || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic results();
        $display("tests %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        check(32'(local_next_page_capable), 32'(LOCAL_NP_RESET));
        rd_word(32'h14);
        check(rd, 32'(ABILITY_RESET));
        rd_word(32'h18);
        check(rd, 32'(EXPANSION_RESET));
        $display("test reset done");
        foreach (rows[i]) begin
            u_lp.caps(i[0], i[1]);
            u_lp.send(rows[i].word, rows[i].word[11]);
            rd_word(32'h14);
            check(rd, 32'(rows[i].exp));
            check(32'(selector_mismatch),
                32'(rows[i].exp[4:0] != ETHERNET_SELECTOR_VALUE));
            rd_word(32'h18);
            check(rd, {28'h0, i[0], 2'b11, i[1]});
        end
        $display("test rows done");
        wr_word(32'h14, 32'h0000ffff);
        check(32'(rs), 32'(RESP_OKAY));
        rd_word(32'h14);
        check(rd, 32'h17e2);
        wr_word(32'h18, 32'h0);
        rd_word(32'h18);
        check(rd, 32'h4);
        // a fault in the read cycle must survive for the next read
        fork
            rd_word(32'h18);
            u_lp.fault();
        join
        check(rd, 32'h4);
        rd_word(32'h18);
        check(rd, 32'h14);
        rd_word(32'h18);
        check(rd, 32'h4);
        $display("test latch done");
        rd_word(32'h40);
        wr_word(32'h44, 32'h3);
        u_lp.fault();
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h1);
        rd_word(32'h40);
        check(rd, 32'h1);
        check(32'(irq), 32'h0);
        wr_word(32'h44, 32'h0);
        u_lp.send(16'h0021, 1'b0);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'h0);
        rd_word(32'h40);
        check(rd, 32'h2);
        $display("test irq done");
        rd_word(32'h30);
        check(32'(rs), 32'(RESP_SLVERR));
        check(rd, 32'h0);
        wr_word(32'h48, 32'h0);
        check(32'(local_next_page_capable), 32'h0);
        // fault from the irq test is still latched: no expansion read since
        rd_word(32'h18);
        check(rd, 32'h12);
        $display("test misc done");
        // second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_word(32'h14);
        check(rd, 32'h0);
        rd_word(32'h18);
        check(rd, 32'h4);
        $display("test rereset done");
        results();
    end
endmodule
